// ===== dcmtl_consts.svh
// Constants for the channel map and task list engine
`ifndef DCMTL_CONSTS_SVH
`define DCMTL_CONSTS_SVH
`define DCMTL_NUM_CH 32
`define DCMTL_NUM_SRC 5
`define DCMTL_SW_CH 5'h1E
`define DCMTL_ALT_OFS 6'h20
`define DCMTL_MODE_STOP 3'h0
`define DCMTL_MODE_BASIC 3'h1
`define DCMTL_MODE_AUTO 3'h2
`define DCMTL_MODE_MEM_SG 3'h4
`define DCMTL_MODE_PER_SG 3'h6
`define DCMTL_CW_MODE_LSB 0
`define DCMTL_CW_CNT_LSB 4
`define DCMTL_CW_SIZE_LSB 16
`define DCMTL_CW_SINC_LSB 18
`define DCMTL_CW_DINC_LSB 20
`define DCMTL_CW_ARB_LSB 22
`define DCMTL_INC_NONE 2'h3
`define DCMTL_SIZE_WORD 2'h2
`define DCMTL_TASK_BYTES 32'h00000010
`define DCMTL_WORD_LAST 2'h2
`endif

// ===== dcmtl_engine.sv
// Multi-channel transfer engine with channel mapping and task lists
`include "dcmtl_consts.svh"
module dcmtl_engine
(
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_resetn,
	// Engine setup
	input  wire logic                 i_engine_en,
	input  wire logic [31:0]          i_ctl_base,
	// Channel control
	input  wire logic [31:0]          i_chan_enable_set,
	input  wire logic [31:0]          i_chan_disable,
	input  wire logic [31:0]          i_alt_select,
	input  wire logic [31:0]          i_sw_request,
	// Request mapping
	input  wire logic [31:0]          i_map_secondary,
	input  wire logic                 i_ext_map_en,
	input  wire logic [95:0]          i_chan_assign,
	input  wire logic [159:0]         i_periph_req,
	// Memory bus
	output logic                      o_mem_req,
	output logic                      o_mem_we,
	output logic [31:0]               o_mem_addr,
	output logic [31:0]               o_mem_wdata,
	output dcmtl_pkg::dcmtl_width_t   o_mem_size,
	input  wire logic                 i_mem_ack,
	input  wire logic [31:0]          i_mem_rdata,
	// Status
	output logic [31:0]               o_chan_enabled,
	output logic [31:0]               o_chan_done,
	output logic                      o_busy
);
	import dcmtl_pkg::*;

	dcmtl_state_e state;
	logic [4:0]   cur_ch;
	logic [5:0]   cur_idx;
	logic [1:0]   word_idx;
	logic [31:0]  src;
	logic [31:0]  dst;
	logic [31:0]  cw;
	logic [31:0]  data;
	logic [10:0]  burst;
	logic         fin;
	dcmtl_mode_t  fin_mode;
	logic [31:0]  alt_phase;
	logic [31:0]  rel_pulse;
	logic [31:0]  pend;
	logic [31:0]  req_sel;
	logic [31:0]  cand;
	logic         hold;
	logic         pick;
	logic [4:0]   pick_ch;
	logic [31:0]  acc_addr;
	logic         acc_we;
	logic [31:0]  acc_wdata;
	dcmtl_width_t acc_size;
	logic [31:0]  src_step;
	logic [31:0]  dst_step;
	logic [10:0]  arb_lim;
	logic [9:0]   cnt;
	dcmtl_mode_t  cur_mode;
	dcmtl_mode_t  rd_mode;
	logic [31:0]  sg_cw;

	// Bytes an address moves per item
	function automatic logic [31:0] inc_bytes(input logic [1:0] code);
		if (code == `DCMTL_INC_NONE)
			inc_bytes = 32'h00000000;
		else
			inc_bytes = 32'h00000001 << code;
	endfunction

	// Control table entries: base, six-bit index, word; low base bits are assumed zero
	function automatic logic [31:0] ent_addr(input logic [31:0] base, input logic [5:0] idx,
		input logic [1:0] w);
		ent_addr = {base[31:10], idx, w, 2'b00};
	endfunction

	// One selector per channel; channel 0 source 0 is usb_ep1_receive_channel, source 1 secondary_uart2_receive_ch0
	genvar g;
	generate
		for (g = 0; g < `DCMTL_NUM_CH; g++)
		begin : g_sel
			dcmtl_req_sel #(.IS_SW(g == `DCMTL_SW_CH)) u_sel (
				.i_clk       (i_clk),
				.i_resetn    (i_resetn),
				.i_src       ({i_periph_req[128 + g], i_periph_req[96 + g], i_periph_req[64 + g],
				               i_periph_req[32 + g], i_periph_req[g]}),
				.i_secondary (i_map_secondary[g]),
				.i_ext_en    (i_ext_map_en),
				.i_assign    (i_chan_assign[3 * g +: 3]),
				.o_req       (req_sel[g])
			);
		end
	endgenerate

	// Field views of the live control word
	assign cnt      = cw[`DCMTL_CW_CNT_LSB +: 10];
	assign cur_mode = cw[`DCMTL_CW_MODE_LSB +: 3];
	assign rd_mode  = i_mem_rdata[`DCMTL_CW_MODE_LSB +: 3];
	assign src_step = inc_bytes(cw[`DCMTL_CW_SINC_LSB +: 2]);
	assign dst_step = inc_bytes(cw[`DCMTL_CW_DINC_LSB +: 2]);
	assign arb_lim  = 11'h001 << cw[`DCMTL_CW_ARB_LSB +: 4];
	assign sg_cw    = (cnt == 10'h000) ? {cw[31:3], `DCMTL_MODE_STOP}
	                  : {cw[31:14], cnt - 10'h001, cw[3:0]};

	// Lowest channel wins; hold one cycle while done or relatch pulses land
	assign cand = (i_engine_en && !hold) ? (o_chan_enabled & (req_sel | pend)) : 32'h00000000;
	assign hold = (|o_chan_done) | (|rel_pulse);
	assign pick = (state == ST_IDLE) && (|cand);
	always_comb
	begin
		pick_ch = 5'h00;
		for (int i = `DCMTL_NUM_CH - 1; i >= 0; i--)
			if (cand[i])
				pick_ch = 5'(i);
	end

	// Address, direction and data of the access each state makes
	always_comb
	begin
		acc_addr  = ent_addr(i_ctl_base, cur_idx, word_idx);
		acc_we    = 1'b0;
		acc_wdata = 32'h00000000;
		acc_size  = `DCMTL_SIZE_WORD;
		case (state)
			ST_SG_RD:
				acc_addr = src + {28'h0000000, word_idx, 2'b00};
			ST_SG_WR:
			begin
				acc_addr  = ent_addr(i_ctl_base, cur_idx + `DCMTL_ALT_OFS, word_idx);
				acc_we    = 1'b1;
				acc_wdata = data;
			end
			ST_SG_PTR:
			begin
				acc_we    = 1'b1;
				acc_wdata = (word_idx == 2'h0) ? src + `DCMTL_TASK_BYTES : (word_idx == 2'h1) ? dst : sg_cw;
			end
			ST_RD:
			begin
				acc_addr = src;
				acc_size = cw[`DCMTL_CW_SIZE_LSB +: 2];
			end
			ST_WR:
			begin
				acc_addr  = dst;
				acc_we    = 1'b1;
				acc_wdata = data; // Bus picks the lanes from address and size
				acc_size  = cw[`DCMTL_CW_SIZE_LSB +: 2];
			end
			ST_WB:
			begin
				acc_we    = 1'b1;
				acc_wdata = (word_idx == 2'h0) ? src : (word_idx == 2'h1) ? dst : cw;
			end
			default:
				acc_we = 1'b0;
		endcase
	end

	// Main sequencer; each access holds request until acknowledged
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state       <= ST_IDLE;
			cur_ch      <= 5'h00;
			cur_idx     <= 6'h00;
			word_idx    <= 2'h0;
			src         <= 32'h00000000;
			dst         <= 32'h00000000;
			cw          <= 32'h00000000;
			data        <= 32'h00000000;
			burst       <= 11'h000;
			fin         <= 1'b0;
			fin_mode    <= `DCMTL_MODE_STOP;
			alt_phase   <= 32'h00000000;
			rel_pulse   <= 32'h00000000;
			o_chan_done <= 32'h00000000;
			o_mem_req   <= 1'b0;
			o_mem_we    <= 1'b0;
			o_mem_addr  <= 32'h00000000;
			o_mem_wdata <= 32'h00000000;
			o_mem_size  <= `DCMTL_SIZE_WORD;
		end
		else
		begin
			o_chan_done <= 32'h00000000;
			rel_pulse   <= 32'h00000000;
			if (state == ST_IDLE)
			begin
				if (pick)
				begin
					cur_ch   <= pick_ch;
					cur_idx  <= (alt_phase[pick_ch] | i_alt_select[pick_ch])
						? {1'b0, pick_ch} + `DCMTL_ALT_OFS : {1'b0, pick_ch};
					word_idx <= 2'h0;
					burst    <= 11'h000;
					fin      <= 1'b0;
					state    <= ST_FETCH;
				end
			end
			else if (!o_mem_req)
			begin
				o_mem_req   <= 1'b1;
				o_mem_we    <= acc_we;
				o_mem_addr  <= acc_addr;
				o_mem_wdata <= acc_wdata;
				o_mem_size  <= acc_size;
			end
			else if (i_mem_ack)
			begin
				o_mem_req <= 1'b0;
				case (state)
					ST_FETCH:
						if (word_idx == 2'h0)
						begin
							src      <= i_mem_rdata;
							word_idx <= 2'h1;
						end
						else if (word_idx == 2'h1)
						begin
							dst      <= i_mem_rdata;
							word_idx <= `DCMTL_WORD_LAST;
						end
						else
						begin
							cw       <= i_mem_rdata;
							word_idx <= 2'h0;
							if (rd_mode == `DCMTL_MODE_STOP)
							begin
								o_chan_done[cur_ch] <= 1'b1;
								alt_phase[cur_ch]   <= 1'b0;
								state               <= ST_IDLE;
							end
							else if (!cur_idx[5] && (rd_mode == `DCMTL_MODE_MEM_SG || rd_mode == `DCMTL_MODE_PER_SG))
								state <= ST_SG_RD;
							else
								state <= ST_RD;
						end
					ST_SG_RD:
					begin
						data  <= i_mem_rdata;
						state <= ST_SG_WR;
					end
					ST_SG_WR:
						if (word_idx == `DCMTL_WORD_LAST)
						begin
							word_idx <= 2'h0;
							state    <= ST_SG_PTR;
						end
						else
						begin
							word_idx <= word_idx + 2'h1;
							state    <= ST_SG_RD;
						end
					ST_SG_PTR:
						if (word_idx == `DCMTL_WORD_LAST)
						begin
							word_idx          <= 2'h0;
							alt_phase[cur_ch] <= 1'b1; // Copied task now runs from the alternate entry
							rel_pulse[cur_ch] <= 1'b1;
							state             <= ST_IDLE;
						end
						else
							word_idx <= word_idx + 2'h1;
					ST_RD:
					begin
						data  <= i_mem_rdata;
						state <= ST_WR;
					end
					ST_WR:
					begin
						src   <= src + src_step;
						dst   <= dst + dst_step;
						burst <= burst + 11'h001;
						if (cnt == 10'h000)
						begin
							cw[`DCMTL_CW_MODE_LSB +: 3] <= `DCMTL_MODE_STOP;
							fin      <= 1'b1;
							fin_mode <= cur_mode;
							state    <= ST_WB;
						end
						else
						begin
							cw[`DCMTL_CW_CNT_LSB +: 10] <= cnt - 10'h001;
							state <= (burst + 11'h001 == arb_lim) ? ST_WB : ST_RD;
						end
					end
					ST_WB:
						if (word_idx == `DCMTL_WORD_LAST)
						begin
							word_idx <= 2'h0;
							state    <= ST_IDLE;
							if (!fin)
							begin
								if (cur_mode == `DCMTL_MODE_AUTO || cur_mode == `DCMTL_MODE_MEM_SG)
									rel_pulse[cur_ch] <= 1'b1;
							end
							else if (alt_phase[cur_ch] && fin_mode[2])
							begin
								alt_phase[cur_ch] <= 1'b0; // Back to the primary for the next task
								rel_pulse[cur_ch] <= 1'b1;
							end
							else
							begin
								alt_phase[cur_ch]   <= 1'b0;
								o_chan_done[cur_ch] <= 1'b1;
							end
						end
						else
							word_idx <= word_idx + 2'h1;
					default:
						state <= ST_IDLE;
				endcase
			end
		end
	end

	// Enables; a software set in the done cycle keeps the channel on
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_chan_enabled <= 32'h00000000;
		else
			o_chan_enabled <= (o_chan_enabled & ~o_chan_done & ~i_chan_disable) | i_chan_enable_set;
	end

	// Latched starts; a new request beats the clear at pick time
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			pend <= 32'h00000000;
		else
			pend <= (pend & ~(pick ? (32'h00000001 << pick_ch) : 32'h00000000)) | i_sw_request | rel_pulse;
	end

	// Busy flag for software polling
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_busy <= 1'b0;
		else
			o_busy <= (state != ST_IDLE);
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_item_done;
		state == ST_WR && o_mem_req && i_mem_ack;
	endsequence
	sequence s_fetch_end;
		state == ST_FETCH && word_idx == `DCMTL_WORD_LAST && o_mem_req && i_mem_ack;
	endsequence

	AST_ALT_INDEX: assert property ((state == ST_FETCH && o_mem_req && alt_phase[cur_ch])
		|-> o_mem_addr[9:4] == {1'b1, cur_ch}) else $error("alternate entry index wrong");
	AST_PRI_INDEX: assert property ((state == ST_FETCH && o_mem_req && !alt_phase[cur_ch] && !i_alt_select[cur_ch])
		|-> o_mem_addr[9:4] == {1'b0, cur_ch}) else $error("primary entry index wrong");
	AST_DONE_CLEARS: assert property (((|o_chan_done) && !(|(o_chan_done & i_chan_enable_set)))
		|=> !(|(o_chan_enabled & $past(o_chan_done)))) else $error("enable survived completion");
	AST_SRC_STEP: assert property (s_item_done |=> src == $past(src) + $past(src_step) && dst == $past(dst) + $past(dst_step))
		else $error("address step wrong");
	AST_SIZE: assert property ((state == ST_RD && o_mem_req)
		|-> o_mem_size == cw[`DCMTL_CW_SIZE_LSB +: 2] && o_mem_size != 2'h3) else $error("item size wrong");
	AST_BURST: assert property ((state == ST_RD || state == ST_WR) |-> burst < arb_lim)
		else $error("burst ran past arbitration size");
	AST_STOP_NO_XFER: assert property ((s_fetch_end and rd_mode == `DCMTL_MODE_STOP)
		|=> state == ST_IDLE && o_chan_done[cur_ch]) else $error("stopped entry transferred");
	AST_SG_COPY: assert property ((s_fetch_end and !cur_idx[5] and rd_mode[2] and rd_mode != `DCMTL_MODE_STOP)
		|=> state == ST_SG_RD ##1 o_mem_req && o_mem_addr == src) else $error("task copy did not start");
	AST_LAST_ITEM: assert property ((s_item_done and cnt == 10'h000) |=> fin && state == ST_WB)
		else $error("final item not closed");
endmodule

// ===== dcmtl_mem_model.sv
// Memory bus slave model standing in for system SRAM
module dcmtl_mem_model
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// Bus from the engine
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic [1:0]  i_size,
	input  wire logic        i_slow,
	output logic             o_ack,
	output logic [31:0]      o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] words [0:1023];
	logic [1:0]  dly;
	logic [3:0]  lanes;

	// Byte lanes touched by a narrow write
	always_comb lanes = (i_size == 2'h0) ? (4'h1 << i_addr[1:0]) :
		(i_size == 2'h1) ? (4'h3 << {i_addr[1], 1'b0}) : 4'hF;

	// One access at a time, optional wait states; data inverted each cycle outside acks, so the last read value returns every other cycle
	always @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_ack <= 1'b0;
			dly <= 2'h0;
			o_rdata <= 32'h00000000;
		end
		else
		begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			if (i_req && !o_ack)
			begin
				if (dly == 2'h0)
				begin
					o_ack <= 1'b1;
					o_rdata <= words[i_addr[11:2]];
					for (int b = 0; b < 4; b++)
						if (i_we && lanes[b])
							words[i_addr[11:2]][8*b+:8] <= i_wdata[8*b+:8];
					dly <= i_slow ? 2'($urandom_range(3, 0)) : 2'h0;
				end
				else
					dly <= dly - 2'h1;
			end
		end
	end
endmodule

// ===== dcmtl_pkg.sv
// Types shared by the channel map and task list engine
package dcmtl_pkg;
	typedef logic [2:0] dcmtl_mode_t;
	typedef logic [1:0] dcmtl_width_t;
	typedef enum {ST_IDLE, ST_FETCH, ST_SG_RD, ST_SG_WR, ST_SG_PTR, ST_RD, ST_WR, ST_WB} dcmtl_state_e;
endpackage

// ===== dcmtl_req_sel.sv
// Per-channel request source selector with pin synchroniser
module dcmtl_req_sel
#(
	parameter bit IS_SW = 1'b0
)
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	// Request sources and selection
	input  wire logic [4:0] i_src,
	input  wire logic       i_secondary,
	input  wire logic       i_ext_en,
	input  wire logic [2:0] i_assign,
	// Selected request
	output logic            o_req
);
	import dcmtl_pkg::*;

	logic [4:0] sync1;
	logic [4:0] sync2;
	logic       next_req;

	// Two stages before anything looks at the pins
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
		end
		else
		begin
			sync1 <= i_src;
			sync2 <= sync1;
		end
	end

	// Source choice; extended field overrides the two-way select
	always_comb
	begin
		if (IS_SW)
			next_req = 1'b0;
		else if (i_ext_en)
			next_req = (i_assign < 3'h5) ? sync2[i_assign] : 1'b0;
		else
			next_req = i_secondary ? sync2[1] : sync2[0];
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_req <= 1'b0;
		else
			o_req <= next_req;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	AST_SEL_FOLLOW: assert property (($stable(i_src) && $stable(i_secondary) && !i_ext_en)[*4]
		|-> o_req == (!IS_SW && (i_secondary ? i_src[1] : i_src[0]))) else $error("selector output wrong");
	AST_SW_SILENT: assert property (IS_SW |-> ##1 !o_req) else $error("software channel saw a request");
endmodule

// ===== test_dcmtl_engine.sv
// Self-checking bench for the channel map and task list engine
`include "dcmtl_consts.svh"
module test_dcmtl_engine;
	timeunit 1ns;
	timeprecision 1ps;
	import dcmtl_pkg::*;
	logic         clk = 1'b0, resetn = 1'b0, engine_en = 1'b0, ext_map_en = 1'b0, slow = 1'b0;
	logic [31:0]  ctl_base = 32'h00000400, enable_set = '0, chan_disable = '0, alt_select = '0;
	logic [31:0]  sw_request = '0, map_secondary = '0;
	logic [95:0]  chan_assign = '0;
	logic [159:0] periph_req = '0;
	logic         mem_req, mem_we, mem_ack, busy;
	logic [31:0]  mem_addr, mem_wdata, mem_rdata, chan_enabled, chan_done, e;
	dcmtl_width_t mem_size;
	int           num_errors = 0, num_checks = 0, cycles = 0, i, k, w, n, nb, src, idx;
	int           done_q [$];

	dcmtl_engine DUT (.i_clk(clk), .i_resetn(resetn), .i_engine_en(engine_en), .i_ctl_base(ctl_base),
		.i_chan_enable_set(enable_set), .i_chan_disable(chan_disable), .i_alt_select(alt_select),
		.i_sw_request(sw_request), .i_map_secondary(map_secondary), .i_ext_map_en(ext_map_en),
		.i_chan_assign(chan_assign), .i_periph_req(periph_req), .o_mem_req(mem_req), .o_mem_we(mem_we),
		.o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_mem_size(mem_size), .i_mem_ack(mem_ack),
		.i_mem_rdata(mem_rdata), .o_chan_enabled(chan_enabled), .o_chan_done(chan_done), .o_busy(busy));
	dcmtl_mem_model mem (.i_clk(clk), .i_resetn(resetn), .i_req(mem_req), .i_we(mem_we), .i_addr(mem_addr),
		.i_wdata(mem_wdata), .i_size(mem_size), .i_slow(slow), .o_ack(mem_ack), .o_rdata(mem_rdata));

	// Clock at 100 MHz
	always #5 clk = ~clk;

	task check(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task give_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Control word: count stored minus one, arbitration as log2
	function automatic logic [31:0] ctl(logic [2:0] m, int c, logic [1:0] sz, si, di, logic [3:0] arb);
		return {6'h00, arb, di, si, sz, 2'h0, 10'(c - 1), 1'b0, m};
	endfunction

	task entry(int x, logic [31:0] s, logic [31:0] d, logic [31:0] c);
		mem.words[256 + x*4] = s;
		mem.words[257 + x*4] = d;
		mem.words[258 + x*4] = c;
	endtask

	task automatic pulse(ref logic [31:0] sig, input logic [31:0] m);
		@(negedge clk) sig = m;
		@(negedge clk) sig = '0;
	endtask

	// Bounded wait until every noted completion has been seen
	task settle;
		for (w = 0; w < 3000 && (done_q.size() != 0 || busy !== 1'b0); w++)
			@(negedge clk);
		if (w == 3000)
			check("completion", 32'h1, 32'h0);
		repeat (3) @(negedge clk);
	endtask

	task fill;
		for (w = 0; w < 8; w++)
		begin
			mem.words[512 + w] = $urandom;
			mem.words[576 + w] = 32'h00000000;
		end
	endtask

	// Completion watcher takes the oldest noted channel per pulse
	always @(negedge clk)
		if (resetn && chan_done !== 32'h0)
		begin
			if (done_q.size() == 0)
				check("unexpected done", 32'h0, chan_done);
			else
				check("done", 32'h1 << done_q.pop_front(), chan_done);
		end

	// Hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			num_errors++;
			$display("mismatch timeout expected done seen hang");
			give_verdict;
		end
	end

	initial
	begin
		void'($urandom(32'h5e62ee38));
		repeat (8) @(negedge clk);
		resetn = 1'b1;
		engine_en = 1'b1;
		// Software channel in auto mode, so short bursts rearm themselves; words, fixed destination
		fill;
		entry(30, 32'h00000800, 32'h00000900, ctl(`DCMTL_MODE_AUTO, 3, 2'h2, 2'h2, 2'h3, 4'($urandom_range(10, 0))));
		done_q.push_back(30);
		pulse(enable_set, 32'h40000000);
		pulse(sw_request, 32'h40000000);
		settle;
		check("fixed dst", mem.words[514], mem.words[576]);
		check("dst untouched", 32'h0, mem.words[577]);
		check("enabled", 32'h0, chan_enabled);
		check("stop mode", 32'h0, {29'h0, mem.words[256 + 30*4 + 2][2:0]});
		// A stopped entry completes at once and moves nothing
		fill;
		done_q.push_back(30);
		pulse(enable_set, 32'h40000000);
		pulse(sw_request, 32'h40000000);
		settle;
		check("stopped entry moved data", 32'h0, mem.words[576]);
		check("enabled", 32'h0, chan_enabled);
		// Channel 0 through every mapping, primary and alternate structures
		for (i = 0; i < 7; i++)
		begin
			slow = 1'($urandom);
			fill;
			n = $urandom_range(8, 1);
			nb = n << (i % 3);
			idx = (i % 2) * 32;
			alt_select[0] = 1'(i % 2);
			src = (i < 2) ? i : i - 2;
			ext_map_en = (i >= 2);
			map_secondary[0] = 1'(i % 2);
			chan_assign[2:0] = 3'(src);
			entry(idx, 32'h00000800, 32'h00000900, ctl(`DCMTL_MODE_BASIC, n, 2'(i % 3), 2'(i % 3), 2'(i % 3),
				4'($urandom_range(10, 0))));
			entry(idx ^ 32, 32'h0, 32'h0, 32'h0);
			for (k = 0; k < 5; k++)
			begin
				periph_req[32*k] = (k != src);
				periph_req[32*k + 30] = 1'b1;
			end
			pulse(enable_set, 32'h40000001);
			repeat (10) @(negedge clk);
			check("idle with foreign pins", 32'h0, {31'h0, busy});
			done_q.push_back(0);
			periph_req[32*src] = 1'b1;
			settle;
			periph_req = '0;
			for (w = 0; w < 8; w++)
			begin
				e = 32'h0;
				for (k = 0; k < 4; k++)
					if (4*w + k < nb)
						e[8*k+:8] = mem.words[512 + w][8*k+:8];
				check("copied data", e, mem.words[576 + w]);
			end
			pulse(chan_disable, 32'h40000000);
			@(negedge clk);
			check("enabled", 32'h0, chan_enabled);
		end
		alt_select = '0;
		ext_map_en = 1'b0;
		map_secondary = '0;
		chan_assign = '0;
		// Two-task lists, memory then peripheral scatter-gather
		for (k = 0; k < 2; k++)
		begin
			fill;
			mem.words[640] = 32'h00000800;
			mem.words[641] = 32'h00000900;
			mem.words[642] = ctl(k ? `DCMTL_MODE_PER_SG : `DCMTL_MODE_MEM_SG, 1, 2'h2, 2'h2, 2'h2, 4'h0);
			mem.words[644] = 32'h00000804;
			mem.words[645] = 32'h00000904;
			mem.words[646] = ctl(k ? `DCMTL_MODE_BASIC : `DCMTL_MODE_AUTO, 2, 2'h2, 2'h2, 2'h2, 4'h1);
			entry(k ? 0 : 1, 32'h00000A00, 32'h0, ctl(k ? `DCMTL_MODE_PER_SG : `DCMTL_MODE_MEM_SG, 2, 2'h2, 2'h2, 2'h2, 4'h2));
			done_q.push_back(k ? 0 : 1);
			pulse(enable_set, k ? 32'h1 : 32'h2);
			if (k)
				periph_req[0] = 1'b1;
			else
				pulse(sw_request, 32'h2);
			settle;
			periph_req = '0;
			for (w = 0; w < 3; w++)
				check("gathered data", mem.words[512 + w], mem.words[576 + w]);
		end
		give_verdict;
	end
endmodule
